// >>> pkg/mrm_pkg.sv
/*
 * Package for the motion register map: address windows, register offsets,
 * configuration field positions, reset values and carrier structs.
 * Assumes one system clock and a synchronous active-low reset in the user.
 */
package mrm_pkg;

   // ****************************************************************
   // Address windows
   // ****************************************************************
   localparam logic [11:0] MRM_ENG_HW_LO  = 12'hE80;
   localparam logic [11:0] MRM_ENG_HW_HI  = 12'hFFF;
   localparam logic [11:0] MRM_ENG_FW_HI  = 12'h7FF;
   localparam logic [15:0] MRM_BYT_HW_LO  = 16'hF100;
   localparam logic [15:0] MRM_BYT_HW_HI  = 16'hF7FF;
   localparam logic [15:0] MRM_BYT_FW_LO  = 16'h8000;
   localparam logic [15:0] MRM_BYT_FW_HI  = 16'h8FFF;
   localparam int          MRM_RAM_WORDS  = 2048;

   // ****************************************************************
   // Registers (byte bus offsets) and hardware register word indices
   // ****************************************************************
   localparam logic [15:0] MRM_CFG_OFS    = 16'h82E8;
   localparam logic [15:0] MRM_CFG2_OFS   = 16'h82EA;
   localparam logic [8:0]  MRM_HW_PWR     = 9'h000;
   localparam logic [8:0]  MRM_HW_ACV     = 9'h001;
   localparam logic [8:0]  MRM_HW_ACI     = 9'h002;
   localparam logic [8:0]  MRM_HW_MTI     = 9'h003;
   localparam logic [8:0]  MRM_HW_DCV     = 9'h004;
   localparam logic [8:0]  MRM_HW_ACT     = 9'h005;
   localparam logic [15:0] MRM_CFG_RST    = 16'h0000;
   localparam logic [15:0] MRM_CFG2_RST   = 16'h0000;
   localparam logic [15:0] MRM_CFG_MASK   = 16'h01FF;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MRM_DIAG_LSB   = 0;
   localparam int MRM_AIN_BIT    = 4;
   localparam int MRM_FRQ_BIT    = 5;
   localparam int MRM_RATIO_LSB  = 6;
   localparam int MRM_CALC_OFF   = 7;
   localparam int MRM_ACCHK_OFF  = 8;
   localparam int MRM_CLR_CYC    = MRM_RAM_WORDS;

   // Motor current divisor 2.7 as 27/10, so 10/27 of the sum is formed.
   localparam logic [15:0] MRM_MTI_NUM   = 16'd10;
   localparam logic [15:0] MRM_MTI_DEN   = 16'd27;
   localparam logic [15:0] MRM_PWR_DEN   = 16'd10;

   typedef enum {MRM_DIAG_NONE, MRM_DIAG_PARK, MRM_DIAG_START, MRM_DIAG_IREG,
                 MRM_DIAG_VHZ, MRM_DIAG_BAD} mrm_diag_t;
   typedef enum {MRM_R12, MRM_R13, MRM_R14, MRM_R15} mrm_ratio_t;

   // One bus access.
   typedef struct packed {
      logic        en;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mrm_acc_t;

   // Measurement inputs from the sense logic.
   typedef struct packed {
      logic [15:0] acv;
      logic [15:0] aci;
      logic [15:0] iu;
      logic [15:0] iv;
      logic [15:0] iw;
      logic [15:0] mti_scale;
      logic [15:0] dcv;
   } mrm_meas_t;

endpackage : mrm_pkg

// >>> hdl/mrm_top.sv
/*
 * Motion register map: shared RAM, hardware register bank, two bus ports,
 * configuration decode and RMS/power outputs.
 * Assumes both buses run on mclk; byte bus 8-bit, engine bus 16-bit words,
 * read data appears one cycle after the access. Measurement inputs come
 * from logic on mclk.
 */
module mrm_top (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               eng_run,
   input  wire mrm_pkg::mrm_acc_t  eng_acc,
   output logic [15:0]             eng_rdata,
   output logic                    eng_rvalid,
   input  wire logic               byt_en,
   input  wire logic               byt_we,
   input  wire logic [15:0]        byt_addr,
   input  wire logic [7:0]         byt_wdata,
   output logic [7:0]              byt_rdata,
   output logic                    byt_rvalid,
   input  wire mrm_pkg::mrm_meas_t meas,
   input  wire logic               precharge_done,
   input  wire logic               ac_input_fault_flag,
   output logic [3:0]              diagnostic_select,
   output logic                    first_analog_input,
   output logic                    double_frequency_scale,
   output logic [1:0]              pwm_ratio,
   output logic                    pfc_allowed,
   output logic                    ram_clear_busy
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Byte address of a hardware register maps to its engine word offset.
   // The byte window is wider than the engine window, so its upper part has no
   // engine twin; those bytes get an index that no register uses and read zero.
   // Dropping bit 10 instead would alias them onto the measurement registers.
   function automatic logic [8:0] byt_hw_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - mrm_pkg::MRM_BYT_HW_LO;
      byt_hw_idx = d[10] ? 9'h1FF : d[9:1];
   endfunction : byt_hw_idx

   logic        e_hw, e_fw, b_hw, b_fw;
   logic [8:0]  e_idx, b_idx;
   logic [10:0] b_fidx;
   // Window hits for both buses; an access hits at most one window per bus.
   always_comb begin
      e_hw   = eng_acc.en && eng_acc.addr[11:0] >= mrm_pkg::MRM_ENG_HW_LO
               && eng_acc.addr[15:12] == 4'h0;
      e_fw   = eng_acc.en && eng_acc.addr <= {4'h0, mrm_pkg::MRM_ENG_FW_HI};
      e_idx  = 9'(eng_acc.addr[11:0] - mrm_pkg::MRM_ENG_HW_LO);
      b_hw   = byt_en && byt_addr >= mrm_pkg::MRM_BYT_HW_LO
               && byt_addr <= mrm_pkg::MRM_BYT_HW_HI;
      b_fw   = byt_en && byt_addr >= mrm_pkg::MRM_BYT_FW_LO
               && byt_addr <= mrm_pkg::MRM_BYT_FW_HI;
      b_idx  = byt_hw_idx(byt_addr);
      b_fidx = byt_addr[11:1];
   end

   // ****************************************************************
   // Shared data RAM and clear sequence
   // ****************************************************************
   logic [15:0] ram [mrm_pkg::MRM_RAM_WORDS];
   logic [11:0] clr_cnt_r;
   logic        clr_act_r, run_seen_r;

   // Clear starts on the first run after reset so firmware registers read zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clr_cnt_r  <= 12'h000;
         clr_act_r  <= 1'b0;
         run_seen_r <= 1'b0;
      end else if (eng_run && !run_seen_r) begin
         run_seen_r <= 1'b1;
         clr_act_r  <= 1'b1;
         clr_cnt_r  <= 12'h000;
      end else if (clr_act_r) begin
         clr_cnt_r <= clr_cnt_r + 12'h001;
         if (clr_cnt_r == 12'(mrm_pkg::MRM_CLR_CYC - 1))
            clr_act_r <= 1'b0;
      end
   end

   // Clear wins over bus writes; an engine RAM write drops any byte RAM write of the same cycle, whatever word it targets.
   // A write that meets the clear is lost, so firmware must wait for it to end.
   always_ff @(posedge mclk) begin
      if (clr_act_r)
         ram[clr_cnt_r[10:0]] <= 16'h0000;
      else if (e_fw && eng_acc.we)
         ram[eng_acc.addr[10:0]] <= eng_acc.wdata;
      else if (b_fw && byt_we) begin
         if (byt_addr[0])
            ram[b_fidx][15:8] <= byt_wdata;
         else
            ram[b_fidx][7:0] <= byt_wdata;
      end
   end

   // ****************************************************************
   // Configuration registers (held at their byte bus offsets)
   // ****************************************************************
   logic [15:0] cfg_r, cfg2_r;
   logic [15:0] cfg_nxt, cfg2_nxt;
   logic        b_cfg, b_cfg2, e_cfg, e_cfg2;
   // Register hits and next values; the engine word wins over a byte write.
   always_comb begin
      b_cfg   = byt_en && byt_addr[15:1] == mrm_pkg::MRM_CFG_OFS[15:1];
      b_cfg2  = byt_en && byt_addr[15:1] == mrm_pkg::MRM_CFG2_OFS[15:1];
      // The engine sees these words through the firmware mapping, inside its
      // shared RAM window, at half the byte offset above the byte window base.
      e_cfg   = eng_acc.en
                && eng_acc.addr == 16'((mrm_pkg::MRM_CFG_OFS - mrm_pkg::MRM_BYT_FW_LO) >> 1);
      e_cfg2  = eng_acc.en
                && eng_acc.addr == 16'((mrm_pkg::MRM_CFG2_OFS - mrm_pkg::MRM_BYT_FW_LO) >> 1);
      cfg_nxt  = cfg_r;
      cfg2_nxt = cfg2_r;
      if (e_cfg && eng_acc.we)
         cfg_nxt = eng_acc.wdata & mrm_pkg::MRM_CFG_MASK;
      else if (b_cfg && byt_we) begin
         if (byt_addr[0])
            cfg_nxt[15:8] = byt_wdata & mrm_pkg::MRM_CFG_MASK[15:8];
         else
            cfg_nxt[7:0] = byt_wdata;
      end
      if (e_cfg2 && eng_acc.we)
         cfg2_nxt = eng_acc.wdata;
      else if (b_cfg2 && byt_we) begin
         if (byt_addr[0])
            cfg2_nxt[15:8] = byt_wdata;
         else
            cfg2_nxt[7:0] = byt_wdata;
      end
   end

   // Both configuration words return to their hardware values on every reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_r  <= mrm_pkg::MRM_CFG_RST;
         cfg2_r <= mrm_pkg::MRM_CFG2_RST;
      end else begin
         cfg_r  <= cfg_nxt;
         cfg2_r <= cfg2_nxt;
      end
   end

   // ****************************************************************
   // Configuration decode
   // ****************************************************************
   mrm_pkg::mrm_ratio_t ratio_sel;
   // Ratio field decode; bit 6 set overrides the two upper bits.
   always_comb begin
      case (cfg_r[mrm_pkg::MRM_RATIO_LSB +: 3])
         3'b000:  ratio_sel = mrm_pkg::MRM_R12;
         3'b100:  ratio_sel = mrm_pkg::MRM_R15;
         3'b010, 3'b110: ratio_sel = mrm_pkg::MRM_R14;
         default: ratio_sel = mrm_pkg::MRM_R13;
      endcase
   end

   // Ratio is latched only while precharge_done is high; eng_run is not looked at.
   always_ff @(posedge mclk) begin
      if (!rst_n)
         pwm_ratio <= 2'b00;
      else if (precharge_done)
         pwm_ratio <= 2'(ratio_sel);
   end

   // Registered copies of the configuration fields and the PFC gate.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         diagnostic_select      <= 4'h0;
         first_analog_input     <= 1'b0;
         double_frequency_scale <= 1'b0;
         pfc_allowed            <= 1'b0;
      end else begin
         diagnostic_select      <= cfg_r[mrm_pkg::MRM_DIAG_LSB +: 4];
         first_analog_input     <= cfg_r[mrm_pkg::MRM_AIN_BIT];
         double_frequency_scale <= cfg_r[mrm_pkg::MRM_FRQ_BIT];
         pfc_allowed <= cfg2_r[mrm_pkg::MRM_ACCHK_OFF] || !ac_input_fault_flag;
      end
   end

   // ****************************************************************
   // Measurement outputs (read-only hardware registers)
   // ****************************************************************
   logic [15:0] pfc_input_power, ac_voltage_rms, ac_current_rms;
   logic [15:0] motor_current_rms, dc_bus_voltage_out;
   logic [31:0] pwr_prod, mti_den;
   logic [17:0] mag_sum;
   logic [33:0] mag_num;

   // Absolute value of a signed phase current.
   function automatic logic [15:0] mag(input logic [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction : mag

   // Products and phase magnitude sum feeding the measurement registers.
   always_comb begin
      pwr_prod = meas.aci * meas.acv;
      mag_sum  = 18'(mag(meas.iu)) + 18'(mag(meas.iv)) + 18'(mag(meas.iw));
      mag_num  = 34'(mag_sum) * 34'(mrm_pkg::MRM_MTI_NUM);
      mti_den  = meas.mti_scale * mrm_pkg::MRM_MTI_DEN;
   end

   // Dividers are combinational for brevity; a pipelined one trades area for timing.
   // While the calculation is switched off the last results stay readable.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pfc_input_power    <= 16'h0000;
         ac_voltage_rms     <= 16'h0000;
         ac_current_rms     <= 16'h0000;
         motor_current_rms  <= 16'h0000;
         dc_bus_voltage_out <= 16'h0000;
      end else if (!cfg2_r[mrm_pkg::MRM_CALC_OFF]) begin
         pfc_input_power    <= 16'(pwr_prod / 32'(mrm_pkg::MRM_PWR_DEN));
         ac_voltage_rms     <= meas.acv;
         ac_current_rms     <= meas.aci;
         motor_current_rms  <= (mti_den == 32'h0) ? 16'hFFFF
                               : 16'(mag_num / 34'(mti_den));
         dc_bus_voltage_out <= meas.dcv;
      end
   end

   // ****************************************************************
   // Read paths
   // ****************************************************************
   // Hardware register read; unlisted offsets read zero, writes ignored.
   function automatic logic [15:0] hw_read(input logic [8:0] i,
                                           input logic [15:0] p, input logic [15:0] v,
                                           input logic [15:0] c, input logic [15:0] m,
                                           input logic [15:0] d, input logic [15:0] a);
      case (i)
         mrm_pkg::MRM_HW_PWR: hw_read = p;
         mrm_pkg::MRM_HW_ACV: hw_read = v;
         mrm_pkg::MRM_HW_ACI: hw_read = c;
         mrm_pkg::MRM_HW_MTI: hw_read = m;
         mrm_pkg::MRM_HW_DCV: hw_read = d;
         mrm_pkg::MRM_HW_ACT: hw_read = a;
         default:             hw_read = 16'h0000;
      endcase
   endfunction : hw_read

   logic [15:0] act_word;
   assign act_word = {11'h000, pfc_allowed, pwm_ratio, clr_act_r, run_seen_r};

   // Hardware registers have no write decode at all, so writes fall away.
   // Configuration words are checked first, as they sit inside the RAM window.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         eng_rdata  <= 16'h0000;
         eng_rvalid <= 1'b0;
      end else begin
         eng_rvalid <= eng_acc.en && !eng_acc.we;
         if (e_cfg)
            eng_rdata <= cfg_r;
         else if (e_cfg2)
            eng_rdata <= cfg2_r;
         else if (e_fw)
            eng_rdata <= ram[eng_acc.addr[10:0]];
         else if (e_hw)
            eng_rdata <= hw_read(e_idx, pfc_input_power, ac_voltage_rms, ac_current_rms,
                                 motor_current_rms, dc_bus_voltage_out, act_word);
         else
            eng_rdata <= 16'h0000;
      end
   end

   logic [15:0] b_word;
   // Word behind the byte address, in the same priority as the engine read.
   always_comb begin
      if (b_cfg)
         b_word = cfg_r;
      else if (b_cfg2)
         b_word = cfg2_r;
      else if (b_fw)
         b_word = ram[b_fidx];
      else if (b_hw)
         b_word = hw_read(b_idx, pfc_input_power, ac_voltage_rms, ac_current_rms,
                          motor_current_rms, dc_bus_voltage_out, act_word);
      else
         b_word = 16'h0000;
   end

   // Byte read answer one cycle after the request; the odd address picks the
   // high byte, which keeps multi-byte registers little endian.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         byt_rdata  <= 8'h00;
         byt_rvalid <= 1'b0;
      end else begin
         byt_rvalid <= byt_en && !byt_we;
         byt_rdata  <= byt_addr[0] ? b_word[15:8] : b_word[7:0];
      end
   end

   // Busy flag lags the clear by one cycle so that the output comes from a flop.
   always_ff @(posedge mclk) begin
      if (!rst_n)
         ram_clear_busy <= 1'b0;
      else
         ram_clear_busy <= clr_act_r;
   end

endmodule : mrm_top

// >>> bench/mrm_top_monitor.sv
/* Checker for the motion register map, watching only the ports of mrm_top.
   Assumes one clock mclk and the synchronous active-low reset rst_n. */
module mrm_top_monitor (
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire mrm_pkg::mrm_acc_t eng_acc,
   input wire logic [15:0]       eng_rdata,
   input wire logic              eng_rvalid,
   input wire logic              byt_en,
   input wire logic              byt_we,
   input wire logic [15:0]       byt_addr,
   input wire logic [7:0]        byt_rdata,
   input wire logic              byt_rvalid,
   input wire logic              precharge_done,
   input wire logic              ac_input_fault_flag,
   input wire logic [1:0]        pwm_ratio,
   input wire logic              pfc_allowed,
   input wire logic              ram_clear_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CLR_MAX = 2049;
   int clr_cnt_r;

   default clocking mon_cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Length of the current clear run; a stuck clear would block firmware writes forever.
   always_ff @(posedge mclk) begin
      if (!rst_n || !ram_clear_busy)
         clr_cnt_r <= 0;
      else
         clr_cnt_r <= clr_cnt_r + 1;
   end

   // Bus answers, ratio timing, PFC gating and unmapped reads.
   a_byte_read_answer: assert property (byt_en && !byt_we |=> byt_rvalid)
      else $error("byte read without answer");
   a_byte_write_quiet: assert property (byt_en && byt_we |=> !byt_rvalid)
      else $error("byte write gave an answer");
   a_eng_read_answer: assert property (eng_acc.en && !eng_acc.we |=> eng_rvalid)
      else $error("engine read without answer");
   a_answer_has_cause: assert property (byt_rvalid |-> $past(byt_en && !byt_we))
      else $error("byte answer without read");
   a_ratio_held: assert property (!precharge_done |=> $stable(pwm_ratio))
      else $error("ratio changed outside pre-charge end");
   a_pfc_gate: assert property ($past(rst_n) && !ac_input_fault_flag |=> pfc_allowed)
      else $error("pfc blocked without fault");
   a_byte_gap_zero: assert property (byt_en && !byt_we && (byt_addr < 16'h8000 || byt_addr > 16'hF7FF
      || (byt_addr > 16'h8FFF && byt_addr < 16'hF100)) |=> byt_rdata == 8'h00)
      else $error("unmapped byte read not zero");
   a_eng_gap_zero: assert property (eng_acc.en && !eng_acc.we && eng_acc.addr inside {[16'h0800:16'h0E7F]}
      |=> eng_rdata == 16'h0000)
      else $error("unmapped engine read not zero");
   a_clear_bounded: assert property (clr_cnt_r <= CLR_MAX)
      else $error("ram clear runs too long");
endmodule : mrm_top_monitor

bind mrm_top mrm_top_monitor mon_u (.mclk, .rst_n, .eng_acc, .eng_rdata, .eng_rvalid, .byt_en, .byt_we,
   .byt_addr, .byt_rdata, .byt_rvalid, .precharge_done, .ac_input_fault_flag, .pwm_ratio, .pfc_allowed,
   .ram_clear_busy);

// >>> bench/mrm_engine_model.sv
/* Engine-side partner: issues word accesses and the run level.
   Assumes the caller times its calls from the falling edge of mclk. */
module mrm_engine_model (
   input  wire logic        mclk,
   output logic              eng_run,
   output mrm_pkg::mrm_acc_t eng_acc
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle at time zero.
   initial begin
      eng_run = 1'b0;
      eng_acc = '0;
   end

   // One access per call, held for exactly one sampling edge.
   task automatic op(input logic we, input logic [15:0] addr, input logic [15:0] data);
      @(negedge mclk);
      eng_acc = '{en: 1'b1, we: we, addr: addr, wdata: data};
      @(negedge mclk);
      eng_acc = '{en: 1'b0, we: 1'b0, addr: ~addr, wdata: ~data}; // Stale values are not left on the bus.
   endtask : op

   // Running starts only once the controller has loaded its settings.
   task automatic start();
      @(negedge mclk);
      eng_run = 1'b1;
   endtask : start
endmodule : mrm_engine_model

// >>> bench/mrm_top_test.sv
/* Self-checking bench for mrm_top with the engine model on the word bus.
   Assumes the package, design, monitor and engine model are compiled first. */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module mrm_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic               mclk, rst_n, eng_run, eng_rvalid, byt_en, byt_we, byt_rvalid;
   logic               precharge_done, ac_input_fault_flag, first_analog_input, double_frequency_scale;
   logic               pfc_allowed, ram_clear_busy;
   mrm_pkg::mrm_acc_t  eng_acc;
   mrm_pkg::mrm_meas_t meas;
   logic [15:0]        eng_rdata, byt_addr, eexp, hx[5], nx[5];
   logic [7:0]         byt_wdata, byt_rdata, bexp;
   logic [3:0]         diagnostic_select;
   logic [1:0]         pwm_ratio;
   logic [15:0]        eng_q[$];
   logic [7:0]         byt_q[$];
   int                 miscompares = 0;
   int                 check_count = 0;

   mrm_top dut_u (.mclk, .rst_n, .eng_run, .eng_acc, .eng_rdata, .eng_rvalid, .byt_en, .byt_we, .byt_addr,
      .byt_wdata, .byt_rdata, .byt_rvalid, .meas, .precharge_done, .ac_input_fault_flag, .diagnostic_select,
      .first_analog_input, .double_frequency_scale, .pwm_ratio, .pfc_allowed, .ram_clear_busy);
   mrm_engine_model eng_u (.mclk, .eng_run, .eng_acc);

   // Free-running 250 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Each answer is matched to the oldest outstanding read of its bus.
   always @(negedge mclk) begin
      if (byt_rvalid === 1'b1) begin
         bexp = byt_q.pop_front();
         `CHK(byt_rdata, bexp)
      end
      if (eng_rvalid === 1'b1) begin
         eexp = eng_q.pop_front();
         `CHK(eng_rdata, eexp)
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   // Byte access; for a read, d is the expected byte.
   task automatic bop(input logic we, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      byt_en = 1'b1;
      byt_we = we;
      byt_addr = a;
      byt_wdata = d;
      if (!we)
         byt_q.push_back(d);
   endtask : bop

   // Two back-to-back byte accesses, low byte first, then the bus is released.
   task automatic b16(input logic we, input logic [15:0] a, input logic [15:0] v);
      bop(we, a, v[7:0]);
      bop(we, a + 16'h0001, v[15:8]);
      @(negedge mclk);
      byt_en = 1'b0;
      byt_addr = ~byt_addr;
      byt_wdata = ~byt_wdata;
   endtask : b16

   // The note goes in before the access, as the answer is checked on the very
   // falling edge at which the model releases the bus.
   task automatic eop(input logic we, input logic [15:0] a, input logic [15:0] d);
      if (!we)
         eng_q.push_back(d);
      eng_u.op(we, a, d);
   endtask : eop

   // New measurement levels and the results they should produce.
   task automatic set_meas();
      int m[5];
      m = '{$urandom_range(999), $urandom_range(999), $urandom_range(999), $urandom_range(255), $urandom_range(255)};
      meas = '{acv: 16'(m[3]), aci: 16'(m[4]), iu: 16'(m[0]), iv: -16'(m[1]), iw: 16'(m[2]), mti_scale: 16'h0001,
         dcv: 16'($urandom)};
      nx = '{16'(m[3] * m[4] / 10), 16'(m[3]), 16'(m[4]), 16'((m[0] + m[1] + m[2]) * 10 / 27), meas.dcv};
   endtask : set_meas

   task automatic check_hw();
      for (int i = 0; i < 5; i++) begin
         eop(1'b0, 16'hE80 + 16'(i), hx[i]);
         b16(1'b0, 16'hF100 + 16'(2 * i), hx[i]);
      end
   endtask : check_hw

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // A hang is cut off well past the expected few thousand cycles.
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      logic [3:0]  diag[5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h9};
      logic [2:0]  rb[8] = '{3'd4, 3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd5, 3'd7};
      logic [1:0]  rx[8] = '{2'd3, 2'd0, 2'd1, 2'd2, 2'd1, 2'd2, 2'd1, 2'd1};
      logic [1:0]  prev;
      logic [15:0] v, a;
      {rst_n, byt_en, byt_we, precharge_done, ac_input_fault_flag} = '0;
      {byt_addr, byt_wdata, meas} = '0;
      void'($urandom(32'hA0952280));
      cyc(10);
      rst_n = 1'b1;
      `CHK({diagnostic_select, first_analog_input, double_frequency_scale, pwm_ratio, pfc_allowed}, 9'h000)
      b16(1'b0, mrm_pkg::MRM_CFG_OFS, mrm_pkg::MRM_CFG_RST);
      b16(1'b0, mrm_pkg::MRM_CFG2_OFS, mrm_pkg::MRM_CFG2_RST);
      foreach (diag[i]) begin
         v = {10'h000, 1'($urandom), 1'($urandom), diag[i]};
         b16(1'b1, mrm_pkg::MRM_CFG_OFS, v);
         b16(1'b0, mrm_pkg::MRM_CFG_OFS, v);
         `CHK({diagnostic_select, first_analog_input, double_frequency_scale}, {v[3:0], v[4], v[5]})
      end
      // The engine reaches the configuration word at half its byte offset above the byte window base; unused bits read zero.
      eop(1'b1, 16'h0174, 16'hFE35);
      b16(1'b0, mrm_pkg::MRM_CFG_OFS, 16'h0035);
      eop(1'b0, 16'h0174, 16'h0035);
      prev = 2'd0;
      foreach (rb[i]) begin
         b16(1'b1, mrm_pkg::MRM_CFG_OFS, {7'h00, rb[i], 6'h00});
         cyc(2);
         `CHK(pwm_ratio, prev)
         precharge_done = 1'b1;
         cyc(1);
         precharge_done = 1'b0;
         cyc(2);
         `CHK(pwm_ratio, rx[i])
         prev = rx[i];
      end
      for (int k = 0; k < 4; k++) begin
         b16(1'b1, mrm_pkg::MRM_CFG2_OFS, {7'h00, 1'(k >> 1), 8'h00});
         ac_input_fault_flag = 1'(k);
         cyc(2);
         `CHK(pfc_allowed, 1'(k >> 1) | ~1'(k))
      end
      b16(1'b1, 16'h8010, 16'hA55A);
      eng_u.start();
      cyc(3);
      `CHK(ram_clear_busy, 1'b1)
      eop(1'b1, 16'h0009, 16'h1234);
      for (int n = 0; n < 3000 && ram_clear_busy !== 1'b0; n++)
         cyc(1);
      b16(1'b0, 16'h8010, 16'h0000);
      b16(1'b0, 16'h8012, 16'h0000);
      // Upper half of the RAM window only, clear of the configuration words.
      for (int i = 0; i < 5; i++) begin
         a = (i == 0) ? 16'h07FF : {5'h00, 1'b1, 10'($urandom)};
         v = 16'($urandom);
         eop(1'b1, a, v);
         b16(1'b0, 16'h8000 + {a[14:0], 1'b0}, v);
         b16(1'b1, 16'h8000 + {a[14:0], 1'b0}, ~v);
         eop(1'b0, a, ~v);
      end
      set_meas();
      hx = nx;
      cyc(3);
      check_hw();
      eop(1'b1, 16'hE81, ~hx[1]);
      b16(1'b1, 16'hF104, ~hx[2]);
      check_hw();
      b16(1'b1, mrm_pkg::MRM_CFG2_OFS, 16'h0080);
      set_meas();
      cyc(3);
      check_hw();
      b16(1'b1, mrm_pkg::MRM_CFG2_OFS, 16'h0000);
      hx = nx;
      cyc(3);
      check_hw();
      foreach (rx[i]) begin
         v = (i < 4) ? 16'h9000 + 16'(i) : 16'hF7FE + 16'(i * 4);
         b16(1'b1, v, 16'hFFFF);
         b16(1'b0, v, 16'h0000);
      end
      eop(1'b0, 16'h0800, 16'h0000);
      eop(1'b0, 16'h0E7F, 16'h0000);
      cyc(4);
      give_verdict();
   end
endmodule : mrm_top_test
